// File: oag_core.sv
// operand address generator: pointer file, modes, swap sequencing
`timescale 1ns/10ps
`default_nettype none
module oag_core
    import oag_pkg::*;
#(
    parameter int AW = 16
) (
    input  wire logic                        CORE_CLK_I,
    input  wire logic                        ARST_N_I,
    input  wire logic [oag_pkg::INSTR_W-1:0] INSTR_I,
    input  wire logic                        INSTR_VALID_I,
    output logic                             INSTR_READY_O,
    input  wire logic [oag_pkg::DW-1:0]      STORE_DATA_I,
    input  wire logic [oag_pkg::DW-1:0]      ROM_RDATA_I,
    input  wire logic [oag_pkg::DW-1:0]      Y_HIGH_I,
    input  wire logic [oag_pkg::LW-1:0]      ACC_I,
    input  wire logic [oag_pkg::LW-1:0]      YREG_I,
    input  wire logic                        CACHE_PASS_I,
    output logic      [AW-1:0]               RAM_ADDR_O,
    output logic                             RAM_RD_O,
    output logic                             RAM_WR_O,
    output logic      [oag_pkg::DW-1:0]      RAM_WDATA_O,
    output logic      [AW-1:0]               ROM_ADDR_O,
    output logic                             ROM_RD_O,
    output logic      [oag_pkg::DW-1:0]      X_OPERAND_O,
    output logic      [oag_pkg::PW-1:0]      PRODUCT_O,
    output logic      [oag_pkg::LW-1:0]      LOGIC_O,
    output logic                             FLAG_UPD_O,
    output logic                             CACHE_ACTIVE_O,
    output logic      [oag_pkg::CW-1:0]      CACHE_COUNT_O
);
    import oag_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // long immediates arrive as one data word, short ones are nine bits
    initial begin
        if (AW < SI_W || AW > DW) begin
            $error("oag_core: AW must lie between SI_W and DW");
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        oag_state_e           state;
        logic [3:0][AW-1:0]   rptr;
        logic [AW-1:0]        rom_pointer;
        logic [AW-1:0]        i;
        logic [AW-1:0]        j;
        logic [AW-1:0]        k;
        logic [AW-1:0]        modulo_base_addr;
        logic [AW-1:0]        modulo_last_addr;
        logic [AW-1:0]        ram_addr;
        logic [AW-1:0]        rom_addr;
        logic                 ram_rd;
        logic                 ram_wr;
        logic                 rom_rd;
        logic                 flag_upd;
        logic [DW-1:0]        wdata;
        logic [DW-1:0]        temp;
        logic [DW-1:0]        x;
        logic [PW-1:0]        prod;
        logic [LW-1:0]        logic_res;
        logic [TGT_W-1:0]     li_tgt;
        logic [1:0]           sw_sel;
        oag_swap_e            sw_mode;
        logic [CW-1:0]        cache_cnt;
    } oag_state_s;

    oag_state_s st_reg;
    oag_state_s st_next;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic oag_state_s load_reg(
        input oag_state_s       st,
        input logic [TGT_W-1:0] tgt,
        input logic [AW-1:0]    v
    );
        oag_state_s r;
        r = st;
        unique case (tgt)
            T_RP0, T_RP1, T_RP2, T_RP3: r.rptr[tgt[1:0]] = v;
            T_J:     r.j                = v;
            T_K:     r.k                = v;
            T_MBASE: r.modulo_base_addr = v;
            T_MLAST: r.modulo_last_addr = v;
            T_ROMP:  r.rom_pointer      = v;
            T_I:     r.i                = v;
            default: r = st;
        endcase
        return r;
    endfunction

    // post-modification of a RAM access; only a plain +1 may wrap
    function automatic logic [AW:0] mod_step(
        input oag_mod_e      m,
        input logic [AW-1:0] j,
        input logic [AW-1:0] k
    );
        logic [AW:0] r;
        r = '0;
        unique case (m)
            M_NONE:  r = '0;
            M_INC:   r = {1'b1, AW'(STEP_ONE)};
            M_DEC:   r = {1'b0, AW'(-STEP_ONE)};
            M_STEPJ: r = {1'b0, j};
            M_STEPK: r = {1'b0, k};
            M_TWO:   r = {1'b0, AW'(STEP_TWO)};
            default: r = '0;
        endcase
        return r;
    endfunction

    function automatic oag_mod_e ymode_mod(input oag_ymode_e ym);
        oag_mod_e m;
        m = M_NONE;
        unique case (ym)
            Y_PLAIN: m = M_NONE;
            Y_INC:   m = M_INC;
            Y_DEC:   m = M_DEC;
            Y_STEP:  m = M_STEPJ;
        endcase
        return m;
    endfunction

    // swap read phase modification, then write phase modification
    function automatic oag_mod_e swap_mod(
        input logic      wr_phase,
        input oag_swap_e sw
    );
        oag_mod_e m;
        m = M_NONE;
        unique case (sw)
            SW_ZP: m = wr_phase ? M_INC   : M_NONE;
            SW_PZ: m = wr_phase ? M_NONE  : M_INC;
            SW_M2: m = wr_phase ? M_TWO   : M_DEC;
            SW_JK: m = wr_phase ? M_STEPK : M_STEPJ;
        endcase
        return m;
    endfunction

    // ------------------------------------------------------------
    // decode and pointer datapath
    // ------------------------------------------------------------
    oag_class_e    cls;
    oag_ymode_e    ymode;
    oag_swap_e     sw_field;
    oag_lop_e      lop;
    logic          accept;
    logic          wr_phase;
    logic [1:0]    ram_sel;
    logic [AW-1:0] ram_cur;
    oag_mod_e      ram_mod;
    logic [AW:0]   ram_stp;
    logic [AW-1:0] ram_nxt;
    logic [AW-1:0] rom_stp;
    logic [AW-1:0] rom_nxt;
    logic [AW-1:0] si_val;

    assign cls      = oag_class_e'(INSTR_I[CLS_MSB:CLS_LSB]);
    assign ymode    = oag_ymode_e'(INSTR_I[YMODE_MSB:YMODE_LSB]);
    assign sw_field = oag_swap_e'(INSTR_I[SW_MSB:SW_LSB]);
    assign lop      = oag_lop_e'(INSTR_I[LOP_MSB:LOP_LSB]);
    assign wr_phase = (st_reg.state == S_SWAP_WR);
    // the second swap phase holds off the instruction stream
    assign INSTR_READY_O = !wr_phase;
    assign accept   = INSTR_VALID_I && (st_reg.state == S_RUN);
    assign ram_sel  = wr_phase ? st_reg.sw_sel
                               : INSTR_I[PSEL_MSB:PSEL_LSB];
    assign ram_cur  = st_reg.rptr[ram_sel];
    assign ram_mod  = wr_phase ? swap_mod(1'b1, st_reg.sw_mode)
                    : (cls == C_SWAP) ? swap_mod(1'b0, sw_field)
                    : ymode_mod(ymode);
    assign ram_stp  = mod_step(ram_mod, st_reg.j, st_reg.k);
    assign rom_stp  = INSTR_I[XSTEP_BIT] ? st_reg.i
                                         : AW'(STEP_ONE);
    assign si_val   = AW'(INSTR_I[SI_W-1:0]);

    oag_ptr_step #(
        .AW (AW)
    ) u_ram_step (
        .ptr_i     (ram_cur),
        .step_i    (ram_stp[AW-1:0]),
        .wrap_en_i (ram_stp[AW]),
        .base_i    (st_reg.modulo_base_addr),
        .last_i    (st_reg.modulo_last_addr),
        .next_o    (ram_nxt),
        .wrapped_o ()
    );

    // the ROM pointer has no circular buffer of its own
    oag_ptr_step #(
        .AW (AW)
    ) u_rom_step (
        .ptr_i     (st_reg.rom_pointer),
        .step_i    (rom_stp),
        .wrap_en_i (1'b0),
        .base_i    ('0),
        .last_i    ('0),
        .next_o    (rom_nxt),
        .wrapped_o ()
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next          = st_reg;
        st_next.ram_rd   = 1'b0;
        st_next.ram_wr   = 1'b0;
        st_next.rom_rd   = 1'b0;
        st_next.flag_upd = 1'b0;
        if (st_reg.rom_rd) begin
            st_next.x = ROM_RDATA_I;
        end
        if (CACHE_PASS_I && st_reg.cache_cnt != '0) begin
            st_next.cache_cnt = st_reg.cache_cnt - 1'b1;
        end
        unique case (st_reg.state)
            S_RUN: begin
                if (accept) begin
                    unique case (cls)
                        C_MUL_ALU: begin
                            st_next.flag_upd = 1'b1;
                            if (INSTR_I[YEN_BIT]) begin
                                st_next.ram_addr      = ram_cur;
                                st_next.ram_rd        = !INSTR_I[YWR_BIT];
                                st_next.ram_wr        = INSTR_I[YWR_BIT];
                                st_next.wdata         = STORE_DATA_I;
                                st_next.rptr[ram_sel] = ram_nxt;
                            end
                            if (INSTR_I[XEN_BIT]) begin
                                st_next.rom_addr = st_reg.rom_pointer;
                                st_next.rom_rd   = 1'b1;
                                st_next.rom_pointer = rom_nxt;
                            end
                            if (INSTR_I[MUL_BIT]) begin
                                st_next.prod = PW'($signed(st_reg.x)
                                    * $signed(Y_HIGH_I));
                            end
                            unique case (lop)
                                L_NONE: st_next.logic_res = st_reg.logic_res;
                                L_AND:  st_next.logic_res = ACC_I & YREG_I;
                                L_OR:   st_next.logic_res = ACC_I | YREG_I;
                                L_XOR:  st_next.logic_res = ACC_I ^ YREG_I;
                            endcase
                        end
                        C_SPECIAL: begin
                            st_next.flag_upd = 1'b1;
                        end
                        C_CONTROL, C_DATA_MOVE: begin
                            st_next.flag_upd = 1'b0;
                        end
                        C_CACHE: begin
                            st_next.cache_cnt = INSTR_I[CW-1:0];
                        end
                        C_SHORT_IMM: begin
                            st_next = load_reg(st_next,
                                {1'b0, INSTR_I[SI_T_MSB:SI_T_LSB]},
                                si_val);
                        end
                        C_LONG_IMM: begin
                            st_next.li_tgt = INSTR_I[LI_T_MSB:LI_T_LSB];
                            st_next.state  = S_IMM;
                        end
                        C_SWAP: begin
                            // temp = R, then read through the pointer
                            st_next.temp          = STORE_DATA_I;
                            st_next.sw_sel        = ram_sel;
                            st_next.sw_mode       = sw_field;
                            st_next.ram_addr      = ram_cur;
                            st_next.ram_rd        = 1'b1;
                            st_next.rptr[ram_sel] = ram_nxt;
                            st_next.state         = S_SWAP_WR;
                        end
                    endcase
                end
            end
            S_IMM: begin
                // the word after a long immediate opcode is its operand
                if (INSTR_VALID_I) begin
                    st_next = load_reg(st_next, st_reg.li_tgt,
                                       INSTR_I[AW-1:0]);
                    st_next.state = S_RUN;
                end
            end
            S_SWAP_WR: begin
                st_next.ram_addr      = ram_cur;
                st_next.ram_wr        = 1'b1;
                st_next.wdata         = st_reg.temp;
                st_next.rptr[ram_sel] = ram_nxt;
                st_next.state         = S_RUN;
            end
            default: begin
                st_next.state = S_RUN;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign RAM_ADDR_O     = st_reg.ram_addr;
    assign RAM_RD_O       = st_reg.ram_rd;
    assign RAM_WR_O       = st_reg.ram_wr;
    assign RAM_WDATA_O    = st_reg.wdata;
    assign ROM_ADDR_O     = st_reg.rom_addr;
    assign ROM_RD_O       = st_reg.rom_rd;
    assign X_OPERAND_O    = st_reg.x;
    assign PRODUCT_O      = st_reg.prod;
    assign LOGIC_O        = st_reg.logic_res;
    assign FLAG_UPD_O     = st_reg.flag_upd;
    assign CACHE_ACTIVE_O = (st_reg.cache_cnt != '0);
    assign CACHE_COUNT_O  = st_reg.cache_cnt;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    logic y_go;
    assign y_go = accept && cls == C_MUL_ALU && INSTR_I[YEN_BIT];

    sequence seq_swap_read;
        RAM_RD_O && !RAM_WR_O && !INSTR_READY_O;
    endsequence
    sequence seq_swap_write;
        RAM_WR_O && !RAM_RD_O && INSTR_READY_O;
    endsequence

    AST_SWAP_ORDER: assert property (
        accept && cls == C_SWAP |=> seq_swap_read ##1 seq_swap_write)
        else $error("swap did not read then write");
    AST_SWAP_DATA: assert property (
        accept && cls == C_SWAP |-> ##2 RAM_WDATA_O == $past(STORE_DATA_I, 2))
        else $error("swap wrote wrong data");
    AST_PLAIN_KEEP: assert property (
        y_go && ymode == Y_PLAIN && cls == C_MUL_ALU
        |=> st_reg.rptr[$past(ram_sel)] == $past(ram_cur)
            && RAM_ADDR_O == $past(ram_cur))
        else $error("plain indirect moved the pointer");
    AST_POST_INC: assert property (
        y_go && ymode == Y_INC && ram_cur != st_reg.modulo_last_addr
        |=> st_reg.rptr[$past(ram_sel)] == AW'($past(ram_cur) + 1'b1))
        else $error("post-increment wrong");
    AST_POST_DEC: assert property (
        y_go && ymode == Y_DEC
        |=> st_reg.rptr[$past(ram_sel)] == AW'($past(ram_cur) - 1'b1))
        else $error("post-decrement wrong");
    AST_STEP_J: assert property (
        y_go && ymode == Y_STEP
        |=> st_reg.rptr[$past(ram_sel)] == AW'($past(ram_cur)
                                               + $past(st_reg.j)))
        else $error("RAM step wrong");
    AST_WRAP: assert property (
        y_go && ymode == Y_INC && ram_cur == st_reg.modulo_last_addr
        |=> st_reg.rptr[$past(ram_sel)] == $past(st_reg.modulo_base_addr))
        else $error("circular wrap missed");
    AST_SWAP_WRAP: assert property (
        wr_phase && st_reg.sw_mode == SW_ZP
        && ram_cur == st_reg.modulo_last_addr
        |=> st_reg.rptr[$past(ram_sel)] == $past(st_reg.modulo_base_addr))
        else $error("swap write phase wrap missed");
    AST_ROM_STEP: assert property (
        accept && cls == C_MUL_ALU && INSTR_I[XEN_BIT]
        |=> ROM_RD_O && ROM_ADDR_O == $past(st_reg.rom_pointer)
            && st_reg.rom_pointer
               == AW'($past(st_reg.rom_pointer) + $past(rom_stp)))
        else $error("ROM pointer update wrong");
    AST_X_LOAD: assert property (
        ROM_RD_O |=> X_OPERAND_O == $past(ROM_RDATA_I))
        else $error("x register not loaded from ROM");
    AST_PRODUCT: assert property (
        accept && cls == C_MUL_ALU && INSTR_I[MUL_BIT]
        |=> PRODUCT_O == PW'($signed($past(X_OPERAND_O))
                             * $signed($past(Y_HIGH_I))))
        else $error("product wrong");
    AST_NO_FLAGS: assert property (
        accept && cls != C_MUL_ALU && cls != C_SPECIAL |=> !FLAG_UPD_O)
        else $error("flags updated by wrong class");
    AST_LONG_IMM: assert property (
        st_reg.state == S_IMM && st_reg.li_tgt == T_MBASE && INSTR_VALID_I
        |=> st_reg.state == S_RUN
            && st_reg.modulo_base_addr == $past(INSTR_I[AW-1:0]))
        else $error("long immediate operand not loaded");
    AST_SHORT_IMM: assert property (
        accept && cls == C_SHORT_IMM
        && INSTR_I[SI_T_MSB:SI_T_LSB] == T_MLAST[SI_T_MSB-SI_T_LSB:0]
        |=> INSTR_READY_O && st_reg.modulo_last_addr == $past(si_val))
        else $error("short immediate not one cycle");
    AST_CACHE_MAX: assert property (
        CACHE_COUNT_O <= CACHE_MAX)
        else $error("cache count above limit");

endmodule
`default_nettype wire

// File: oag_pkg.sv
// constants and types shared by the operand address generator
package oag_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int INSTR_W = 16;
    localparam int DW      = 16;
    localparam int PW      = 32;
    localparam int LW      = 32;
    localparam int CW      = 7;
    localparam int SI_W    = 9;
    localparam int TGT_W   = 4;

    // ------------------------------------------------------------
    // instruction word fields
    // ------------------------------------------------------------
    localparam int CLS_MSB   = 15;
    localparam int CLS_LSB   = 13;
    localparam int PSEL_MSB  = 12;
    localparam int PSEL_LSB  = 11;
    localparam int YMODE_MSB = 10;
    localparam int YMODE_LSB = 9;
    localparam int YEN_BIT   = 8;
    localparam int YWR_BIT   = 7;
    localparam int XEN_BIT   = 6;
    localparam int XSTEP_BIT = 5;
    localparam int LOP_MSB   = 4;
    localparam int LOP_LSB   = 3;
    localparam int MUL_BIT   = 2;
    localparam int SI_T_MSB  = 11;
    localparam int SI_T_LSB  = 9;
    localparam int LI_T_MSB  = 12;
    localparam int LI_T_LSB  = 9;
    localparam int SW_MSB    = 10;
    localparam int SW_LSB    = 9;

    // ------------------------------------------------------------
    // load targets, steps and limits
    // ------------------------------------------------------------
    localparam logic [TGT_W-1:0] T_RP0   = 4'h0;
    localparam logic [TGT_W-1:0] T_RP1   = 4'h1;
    localparam logic [TGT_W-1:0] T_RP2   = 4'h2;
    localparam logic [TGT_W-1:0] T_RP3   = 4'h3;
    localparam logic [TGT_W-1:0] T_J     = 4'h4;
    localparam logic [TGT_W-1:0] T_K     = 4'h5;
    localparam logic [TGT_W-1:0] T_MBASE = 4'h6;
    localparam logic [TGT_W-1:0] T_MLAST = 4'h7;
    localparam logic [TGT_W-1:0] T_ROMP  = 4'h8;
    localparam logic [TGT_W-1:0] T_I     = 4'h9;
    localparam int               STEP_ONE  = 1;
    localparam int               STEP_TWO  = 2;
    localparam logic [CW-1:0]    CACHE_MAX = 7'h7F;

    typedef enum logic [2:0] {
        C_MUL_ALU, C_SPECIAL, C_CONTROL, C_DATA_MOVE,
        C_CACHE, C_SHORT_IMM, C_LONG_IMM, C_SWAP
    } oag_class_e;
    typedef enum logic [1:0] {Y_PLAIN, Y_INC, Y_DEC, Y_STEP} oag_ymode_e;
    typedef enum logic [1:0] {SW_ZP, SW_PZ, SW_M2, SW_JK} oag_swap_e;
    typedef enum logic [1:0] {L_NONE, L_AND, L_OR, L_XOR} oag_lop_e;
    typedef enum logic [1:0] {S_RUN, S_IMM, S_SWAP_WR} oag_state_e;
    typedef enum logic [2:0] {
        M_NONE, M_INC, M_DEC, M_STEPJ, M_STEPK, M_TWO
    } oag_mod_e;

endpackage

// File: oag_ptr_step.sv
// pointer post-modification with circular-buffer wrap
`timescale 1ns/10ps
`default_nettype none
module oag_ptr_step #(
    parameter int AW = 16
) (
    input  wire logic [AW-1:0] ptr_i,
    input  wire logic [AW-1:0] step_i,
    input  wire logic          wrap_en_i,
    input  wire logic [AW-1:0] base_i,
    input  wire logic [AW-1:0] last_i,
    output logic      [AW-1:0] next_o,
    output logic               wrapped_o
);

    initial begin
        if (AW < 1) begin
            $error("oag_ptr_step: AW must be positive");
        end
    end

    // the step is two's complement, so a negative step simply wraps the
    // adder and moves the pointer down
    assign wrapped_o = wrap_en_i && (ptr_i == last_i);
    assign next_o    = wrapped_o ? base_i : ptr_i + step_i;

endmodule
`default_nettype wire

// File: tb_oag_core.sv
// self-checking bench for the operand address generator
`timescale 1ns/10ps
`default_nettype none
module tb_oag_core;
    import oag_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] ins = 16'h0000;
    logic [15:0] sdat = 16'hBEEF;
    logic        vld = 1'b0;
    logic        cpass = 1'b0;
    logic        rdy, rrd, rwr, xrd, flg, cact;
    logic [15:0] radr, wdat, xadr, xop;
    logic [31:0] prod, lres;
    logic [6:0]  ccnt;
    logic [31:0] lx [1:3] = '{32'h00F0_1200, 32'hFFF0_FF34, 32'hFF00_ED34};
    logic [3:0]  yseq [7] = '{4'h1, 4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h3};
    logic [15:0] aseq [7] = '{16'h30, 16'h10, 16'h10, 16'h10, 16'h11,
                              16'h08, 16'h07};
    int          num_errors = 0;
    int          total_checks = 0;

    oag_core #(.AW(16)) dut_u (
        .CORE_CLK_I(clk), .ARST_N_I(rst_n), .INSTR_I(ins),
        .INSTR_VALID_I(vld), .INSTR_READY_O(rdy),
        .STORE_DATA_I(sdat), .ROM_RDATA_I(16'h1234),
        .Y_HIGH_I(16'hFFFE), .ACC_I(32'hF0F0_1234), .YREG_I(32'h0FF0_FF00),
        .CACHE_PASS_I(cpass), .RAM_ADDR_O(radr), .RAM_RD_O(rrd),
        .RAM_WR_O(rwr), .RAM_WDATA_O(wdat), .ROM_ADDR_O(xadr),
        .ROM_RD_O(xrd), .X_OPERAND_O(xop), .PRODUCT_O(prod),
        .LOGIC_O(lres), .FLAG_UPD_O(flg), .CACHE_ACTIVE_O(cact),
        .CACHE_COUNT_O(ccnt)
    );

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one word taken per call; returns mid-cycle after the answer lands
    task automatic op(input logic [15:0] w);
        @(posedge clk);
        ins <= w;
        vld <= 1'b1;
        @(posedge clk);
        vld <= 1'b0;
        @(negedge clk);
    endtask

    task automatic end_of_test;
        if (num_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // pointers 3 then 0 walked through ++, plain, wrap at last, --, ++j of -2
    task automatic t_ymode;
        op(16'hA630);
        op(16'hA010);
        op(16'hCC00);
        op(16'h0008);
        op(16'hAE11);
        op(16'hC800);
        op(16'hFFFE);
        for (int n = 0; n < 7; n++) begin
            op({3'd0, yseq[n][3:2] ^ {2{n == 0}}, yseq[n][1:0], 9'h100});
            chk({rrd, flg, radr}, {2'b11, aseq[n]});
        end
        // a data move touches no RAM, so the last address stays
        op(16'h6100);
        chk({flg, radr}, {1'b0, 16'h07});
        op(16'h0100);
        chk(radr, 16'h05);
    endtask

    // swap at the last address: wrap only in the write phase
    task automatic t_swap;
        op(16'hA011);
        op(16'hE000);
        chk({rrd, rwr, rdy, radr}, {3'b100, 16'h11});
        @(posedge clk);
        sdat <= 16'h5A5A;
        @(negedge clk);
        chk({rwr, rdy, radr, wdat}, {2'b11, 16'h11, 16'hBEEF});
        op(16'h0180);
        chk({rwr, radr, wdat}, {1'b1, 16'h08, 16'h5A5A});
    endtask

    // rom pointer ++ and ++i with i = -1, operand into x
    task automatic t_rom;
        op(16'hD000);
        op(16'h0020);
        op(16'hD200);
        op(16'hFFFF);
        op(16'h0040);
        chk({xrd, xadr}, {1'b1, 16'h20});
        op(16'h0060);
        chk({xop, xadr}, {16'h1234, 16'h21});
        op(16'h0040);
        chk(xadr, 16'h20);
    endtask

    task automatic t_alu;
        op(16'h0004);
        chk(prod, 32'hFFFF_DB98);
        for (int n = 1; n < 4; n++) begin
            op({11'h000, n[1:0], 3'b000});
            chk(lres, lx[n]);
        end
    endtask

    task automatic t_cache;
        op(16'h807F);
        chk({cact, ccnt}, {1'b1, 7'h7F});
        @(posedge clk);
        cpass <= 1'b1;
        @(posedge clk);
        cpass <= 1'b0;
        @(negedge clk);
        chk(ccnt, 7'h7E);
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and sequence
    // ------------------------------------------------------------
    initial begin
        forever #25 clk = ~clk;
    end

    initial begin
        #200000;
        num_errors++;
        end_of_test;
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_ymode;
        t_swap;
        t_rom;
        t_alu;
        t_cache;
        end_of_test;
    end
endmodule
`default_nettype wire
